// ### qpd_params.svh
`ifndef QPD_PARAMS_SVH
`define QPD_PARAMS_SVH

// device-type code, value arbitrary
`define QPD_DEV_TYPE 4'h6
// fixed instruction byte of the status read
`define QPD_STATUS_BYTE 8'h51
// reset value of every setting and wiper register
`define QPD_SETTING_RESET 8'h80
// bit of the status byte that carries the write-busy flag
`define QPD_BUSY_BIT 0
// identification byte fields
`define QPD_ID_TYPE_HI 7
`define QPD_ID_TYPE_LO 4
`define QPD_ID_ADDR_HI 1
`define QPD_ID_ADDR_LO 0
// instruction byte fields
`define QPD_OP_HI 7
`define QPD_OP_LO 4
`define QPD_SEL_HI 3
`define QPD_SEL_LO 2
`define QPD_CH_HI 1
`define QPD_CH_LO 0
// timing
`define QPD_CLK_HZ 10000000
`define QPD_NV_WRITE_MS 10
`define QPD_SETTLE_NS 1000

`endif

// ### qpd_pkg.sv
`default_nettype none
package qpd_pkg;

	// instruction opcodes
	typedef enum logic [3:0] {
		OP_G_SET2WIPER = 4'h1,
		OP_STEP = 4'h2,
		OP_STATUS = 4'h5,
		OP_G_WIPER2SET = 4'h8,
		OP_RD_WIPER = 4'h9,
		OP_WR_WIPER = 4'hA,
		OP_RD_SET = 4'hB,
		OP_WR_SET = 4'hC,
		OP_SET2WIPER = 4'hD,
		OP_WIPER2SET = 4'hE
	} qpd_op_t;

	// decoded command handed from the link to the core
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] sel;
		logic [1:0] ch;
		logic [7:0] data;
	} qpd_cmd_t;

	// link-side sequence states, gray along id, instr, data, done
	typedef enum logic [2:0] {
		LS_ID = 3'h0,
		LS_INSTR = 3'h1,
		LS_DATA = 3'h3,
		LS_DONE = 3'h2,
		LS_STEP = 3'h6,
		LS_OUT = 3'h7,
		LS_IGNORE = 3'h5
	} qpd_lst_t;

endpackage
`default_nettype wire

// ### qpd_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpd_params.svh"

module qpd_link (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic rst,
	input wire logic si,
	input wire logic [1:0] strap,
	input wire logic [3:0] dev_type,
	input wire logic [7:0] rd_data,
	output logic so,
	output logic so_oe,
	output qpd_pkg::qpd_cmd_t cmd,
	output logic done
);
	import qpd_pkg::*;

	// route after the instruction byte
	function automatic qpd_lst_t route(input logic [7:0] b);
		logic sel0;
		logic ch0;
		sel0 = (b[`QPD_SEL_HI:`QPD_SEL_LO] == 2'h0);
		ch0 = (b[`QPD_CH_HI:`QPD_CH_LO] == 2'h0);
		case (b[`QPD_OP_HI:`QPD_OP_LO])
			OP_WR_WIPER: route = sel0 ? LS_DATA : LS_IGNORE;
			OP_WR_SET: route = LS_DATA;
			OP_RD_WIPER: route = sel0 ? LS_OUT : LS_IGNORE;
			OP_RD_SET: route = LS_OUT;
			OP_STATUS: route = (b == `QPD_STATUS_BYTE) ? LS_OUT : LS_IGNORE;
			OP_SET2WIPER, OP_WIPER2SET: route = LS_DONE;
			OP_G_SET2WIPER, OP_G_WIPER2SET: route = ch0 ? LS_DONE : LS_IGNORE;
			OP_STEP: route = sel0 ? LS_STEP : LS_IGNORE;
			default: route = LS_IGNORE;
		endcase
	endfunction

	qpd_lst_t st_q;
	logic [6:0] sr_q;
	logic [2:0] cnt_q;
	logic [1:0] strap_m_q;
	logic [1:0] strap_q;
	logic [7:0] out_q;
	logic ld_q;
	logic first_q;
	qpd_cmd_t cmd_q;
	logic done_q;

	// byte decode on the bit being captured
	wire [7:0] byte_w = {sr_q, si};
	wire last_w = (cnt_q == 3'h7);
	wire type_ok_w = (byte_w[`QPD_ID_TYPE_HI:`QPD_ID_TYPE_LO] == dev_type);
	wire addr_ok_w = (byte_w[`QPD_ID_ADDR_HI:`QPD_ID_ADDR_LO] == strap_q);
	wire qpd_lst_t nxt_w = route(byte_w);
	wire frame_start_w = (st_q == LS_ID) && (cnt_q == 3'h0);
	wire [7:0] base_w = first_q ? rd_data : cmd_q.data;
	wire [7:0] up_w = (base_w == 8'hFF) ? base_w : base_w + 8'h01;
	wire [7:0] dn_w = (base_w == 8'h00) ? base_w : base_w - 8'h01;

	// strap pins pass two flops before compare
	always_ff @(posedge sck) begin
		strap_m_q <= strap;
		strap_q <= strap_m_q;
	end

	// sequence state, cleared while deselected; input captured on rising sck
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			st_q <= LS_ID;
			sr_q <= 7'h00;
			cnt_q <= 3'h0;
			first_q <= 1'b1;
		end else begin
			sr_q <= byte_w[6:0];
			cnt_q <= cnt_q + 3'h1;
			case (st_q)
				LS_ID: if (last_w) begin
					st_q <= (type_ok_w && addr_ok_w) ? LS_INSTR : LS_IGNORE;
				end
				LS_INSTR: if (last_w) begin
					st_q <= nxt_w;
				end
				LS_DATA: if (last_w) begin
					st_q <= LS_DONE;
				end
				LS_OUT: if (last_w) begin
					st_q <= LS_DONE;
				end
				LS_STEP: first_q <= 1'b0;
				default: st_q <= st_q;
			endcase
		end
	end

	// command and completion flag survive deselect for the core to act on
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			cmd_q <= '0;
			done_q <= 1'b0;
		end else if (!cs_n) begin
			if (frame_start_w) begin
				done_q <= 1'b0;
			end
			if (st_q == LS_INSTR && last_w) begin
				cmd_q.op <= byte_w[`QPD_OP_HI:`QPD_OP_LO];
				cmd_q.sel <= byte_w[`QPD_SEL_HI:`QPD_SEL_LO];
				cmd_q.ch <= byte_w[`QPD_CH_HI:`QPD_CH_LO];
				done_q <= (nxt_w == LS_DONE);
			end
			if (st_q == LS_DATA && last_w) begin
				cmd_q.data <= byte_w;
				done_q <= 1'b1;
			end
			if (st_q == LS_STEP) begin
				cmd_q.data <= si ? up_w : dn_w;
				done_q <= 1'b1;
			end
		end
	end

	// read byte shifted out on falling sck
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			out_q <= 8'h00;
			ld_q <= 1'b0;
		end else if (st_q == LS_OUT) begin
			if (!ld_q) begin
				out_q <= rd_data;
				ld_q <= 1'b1;
			end else begin
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// output drives only during the read byte
	assign so = out_q[7];
	assign so_oe = (st_q == LS_OUT) && ld_q;
	assign cmd = cmd_q;
	assign done = done_q;

endmodule
`default_nettype wire

// ### qpd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpd_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - first byte after select is the id; its upper four bits must match the type
// - id low two bits must equal the address strap inputs to continue
// - second byte: opcode, setting index, channel
// - the four copy commands end after the instruction byte
// - 1001 reads a wiper position, 1010 loads it from the third byte
// - 1011 reads a setting register, 1100 writes it from the third byte
// - 1101 copies the chosen setting into that channel's wiper
// - 1110 copies the wiper into the chosen setting, nonvolatile
// - 0001 with channel 00 loads every wiper from its chosen setting
// - 1000 with channel 00 stores every wiper into its chosen setting
// - 0010 steps the chosen wiper until the command ends
// - clock pulse with input high increments the wiper
// - clock pulse with input low decrements the wiper
// - settings commit only on select rising after a complete write
// - write-busy flag set during a nonvolatile write, readable by status
// - status byte 0101 0001 returns the write-busy flag
// - store into setting lasts the write time; load into wiper settles briefly
// - write-lock input low blocks all nonvolatile writes
// - at power-up each wiper loads from its setting zero
// - input captured on rising clock, read data shifted on falling clock
module qpd_top #(
	parameter int NV_CYCLES = `QPD_NV_WRITE_MS * (`QPD_CLK_HZ / 1000),
	parameter logic [3:0] DEV_TYPE = `QPD_DEV_TYPE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic [1:0] addr_strap_pins,
	input wire logic wp_n,
	output logic [3:0][7:0] wiper_pos,
	output logic write_busy_flag
);
	import qpd_pkg::*;

	localparam int SETTLE_RAW = (`QPD_SETTLE_NS * (`QPD_CLK_HZ / 1000000)) / 1000;
	localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
	localparam int NVW = $clog2(NV_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////////
	// link side

	qpd_cmd_t lcmd;
	logic ldone;
	logic [7:0] rd_data;

	qpd_link u_link (
		.sck(sck),
		.cs_n(cs_n),
		.rst(rst),
		.si(si),
		.strap(addr_strap_pins),
		.dev_type(DEV_TYPE),
		.rd_data(rd_data),
		.so(so),
		.so_oe(so_oe),
		.cmd(lcmd),
		.done(ldone)
	);

	////////////////////////////////////////////////////////////////////////////
	// crossing into the system clock

	logic cs_m_q;
	logic cs_s_q;
	logic cs_prev_q;
	logic done_m_q;
	logic done_s_q;
	logic wp_m_q;
	logic wp_s_q;

	// two-flop synchronisers for select, completion and write lock
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			cs_prev_q <= 1'b1;
			done_m_q <= 1'b0;
			done_s_q <= 1'b0;
			wp_m_q <= 1'b0;
			wp_s_q <= 1'b0;
		end else begin
			cs_m_q <= cs_n;
			cs_s_q <= cs_m_q;
			cs_prev_q <= cs_s_q;
			done_m_q <= ldone;
			done_s_q <= done_m_q;
			wp_m_q <= wp_n;
			wp_s_q <= wp_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register storage and control state

	logic [3:0][7:0] wcr_q;
	logic [3:0][7:0] wcr_d;
	logic [3:0][3:0][7:0] set_q;
	logic [3:0][3:0][7:0] set_d;
	logic boot_q;
	logic [NVW-1:0] nv_cnt_q;
	logic pend_q;
	logic [7:0] pend_cnt_q;
	logic pend_all_q;
	logic [1:0] pend_sel_q;
	logic [1:0] pend_ch_q;

	// command execution decode; command is stable once select is high
	wire go_w = cs_s_q && !cs_prev_q && done_s_q;
	wire busy_w = (nv_cnt_q != '0);
	wire nv_ok_w = !busy_w && wp_s_q;
	wire op_wr_wiper_w = (lcmd.op == OP_WR_WIPER) || (lcmd.op == OP_STEP);
	wire op_wr_set_w = (lcmd.op == OP_WR_SET);
	wire op_to_set_w = (lcmd.op == OP_WIPER2SET) || op_wr_set_w;
	wire op_g_to_set_w = (lcmd.op == OP_G_WIPER2SET);
	wire op_to_wiper_w = (lcmd.op == OP_SET2WIPER);
	wire op_g_to_wiper_w = (lcmd.op == OP_G_SET2WIPER);
	wire nv_go_w = go_w && nv_ok_w && (op_to_set_w || op_g_to_set_w);
	wire settle_go_w = go_w && (op_to_wiper_w || op_g_to_wiper_w);
	wire settle_fire_w = pend_q && (pend_cnt_q == 8'h01);

	// per-channel next values
	genvar c;
	genvar r;
	generate
		for (c = 0; c < 4; c++) begin : g_ch
			wire hit_w = (lcmd.ch == 2'(c));
			wire wr_w = go_w && op_wr_wiper_w && hit_w;
			wire load_w = settle_fire_w && (pend_all_q || pend_ch_q == 2'(c));
			wire nv_hit_w = nv_go_w && (op_g_to_set_w || hit_w);
			wire [7:0] nv_val_w = op_wr_set_w ? lcmd.data : wcr_q[c];
			assign wcr_d[c] = boot_q ? set_q[c][0] :
				wr_w ? lcmd.data :
				load_w ? set_q[c][pend_sel_q] : wcr_q[c];
			for (r = 0; r < 4; r++) begin : g_reg
				wire sel_w = nv_hit_w && (lcmd.sel == 2'(r));
				assign set_d[c][r] = sel_w ? nv_val_w : set_q[c][r];
			end
		end
	endgenerate

	// wiper and setting registers
	always_ff @(posedge clk) begin
		if (rst) begin
			wcr_q <= {4{`QPD_SETTING_RESET}};
			set_q <= {16{`QPD_SETTING_RESET}};
			boot_q <= 1'b1;
		end else begin
			wcr_q <= wcr_d;
			set_q <= set_d;
			boot_q <= 1'b0;
		end
	end

	// nonvolatile write timer
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_cnt_q <= '0;
		end else if (nv_go_w) begin
			nv_cnt_q <= NVW'(NV_CYCLES);
		end else if (busy_w) begin
			nv_cnt_q <= nv_cnt_q - NVW'(1);
		end
	end

	// delayed load of setting into wiper
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q <= 1'b0;
			pend_cnt_q <= 8'h00;
			pend_all_q <= 1'b0;
			pend_sel_q <= 2'h0;
			pend_ch_q <= 2'h0;
		end else if (settle_go_w) begin
			pend_q <= 1'b1;
			pend_cnt_q <= 8'(SETTLE_CYCLES);
			pend_all_q <= op_g_to_wiper_w;
			pend_sel_q <= lcmd.sel;
			pend_ch_q <= lcmd.ch;
		end else if (pend_q) begin
			pend_q <= !settle_fire_w;
			pend_cnt_q <= pend_cnt_q - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path and outputs

	// read byte held steady while the link reads it
	wire [7:0] status_w = 8'(busy_w) << `QPD_BUSY_BIT;
	assign rd_data = (lcmd.op == OP_RD_SET) ? set_q[lcmd.ch][lcmd.sel] :
		(lcmd.op == OP_STATUS) ? status_w :
		wcr_q[lcmd.ch];

	// tap index: 00 low terminal, FF high terminal
	assign wiper_pos = wcr_q;
	assign write_busy_flag = busy_w;

endmodule
`default_nettype wire

// ### qpd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpd_params.svh"

module qpd_top_props #(
	parameter int NV_CYCLES = 20,
	parameter logic [3:0] DEV_TYPE = 4'h6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so_oe,
	input wire logic [1:0] addr_strap_pins,
	input wire logic wp_n,
	input wire logic [3:0][7:0] wiper_pos,
	input wire logic write_busy_flag
);
	logic [5:0] bit_q;
	logic [6:0] sh_q;
	logic [7:0] id_q;
	logic [7:0] ins_q;
	int busy_q;
	logic rd_ok;
	logic in_rd;
	// bit count cleared while deselected; header capture keeps its bytes across frames
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			bit_q <= 6'h00;
		end else begin
			bit_q <= (bit_q == 6'h3F) ? bit_q : bit_q + 6'h01;
			sh_q <= {sh_q[5:0], si};
			id_q <= (bit_q == 6'h07) ? {sh_q, si} : id_q;
			ins_q <= (bit_q == 6'h0F) ? {sh_q, si} : ins_q;
		end
	end
	// length of the running busy window
	always_ff @(posedge clk) begin
		busy_q <= (rst || !write_busy_flag) ? 0 : busy_q + 1;
	end
	// read frame with matching id, inside the third byte
	assign rd_ok = id_q[7:4] == DEV_TYPE && id_q[1:0] == addr_strap_pins
		&& (ins_q == `QPD_STATUS_BYTE || ins_q[7:4] == 4'hB || ins_q[7:2] == 6'h24);
	assign in_rd = bit_q >= 6'h10 && bit_q <= 6'h17;

	a_oe_when_selected: assert property (@(posedge clk) disable iff (rst)
		so_oe |-> !cs_n) else $error("output enabled while deselected");
	a_boot_wipers: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> wiper_pos == {4{`QPD_SETTING_RESET}}) else $error("boot wipers wrong");
	a_busy_span: assert property (@(posedge clk) disable iff (rst)
		$fell(write_busy_flag) && !$past(rst) |-> busy_q >= NV_CYCLES - 1
		&& busy_q <= NV_CYCLES + 1) else $error("busy window length wrong");
	a_busy_capped: assert property (@(posedge clk) disable iff (rst)
		write_busy_flag |-> busy_q <= NV_CYCLES + 1) else $error("busy never ends");
	a_busy_after_frame: assert property (@(posedge clk) disable iff (rst)
		$rose(write_busy_flag) |-> cs_n && $past(cs_n)) else $error("write began in frame");
	a_lock_holds: assert property (@(posedge clk) disable iff (rst)
		(!wp_n) [*8] |-> !$rose(write_busy_flag)) else $error("write while locked");
	a_oe_window: assert property (@(posedge sck) disable iff (cs_n)
		so_oe |-> in_rd && rd_ok) else $error("output enabled outside read byte");
	a_read_drives: assert property (@(posedge sck) disable iff (cs_n)
		in_rd && rd_ok |-> so_oe) else $error("read byte not driven");
endmodule

bind qpd_top qpd_top_props #(.NV_CYCLES(NV_CYCLES), .DEV_TYPE(DEV_TYPE)) props_u (
	.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so_oe(so_oe),
	.addr_strap_pins(addr_strap_pins), .wp_n(wp_n), .wiper_pos(wiper_pos),
	.write_busy_flag(write_busy_flag));
`default_nettype wire

// ### qpd_spi_master.sv
`timescale 1ns/1ps
`default_nettype none

module qpd_spi_master (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// one frame, msb first, id byte leading; keeps the last byte seen
	task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] r);
		r = 8'h00;
		cs_n = 1'b0;
		#50;
		for (int i = 0; i < n; i++) begin
			si = d[23 - i];
			#3 sck = 1'b1;
			r = {r[6:0], so};
			#3 sck = 1'b0;
		end
		si = ~si; // released line shows the inverse
		#400 cs_n = 1'b1;
		#2000;
	endtask
endmodule
`default_nettype wire

// ### quad_pot_spi_command_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpd_params.svh"

module quad_pot_spi_command_decoder_tb_top;
	localparam int NV = 60;
	localparam logic [3:0] DT = 4'hA; // arbitrary type code
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic [1:0] ap = 2'h2;
	wire logic sck, cs_n, si, so, so_oe, busy;
	wire logic [3:0][7:0] wpos;
	wire logic so_w = so_oe ? so : ~sck;
	wire logic [7:0] id = {DT, 2'b00, ap};
	logic [7:0] rb, v;
	logic [7:0] sv[3] = '{8'hFD, 8'h02, 8'h80};
	logic [7:0] sp[3] = '{8'hF0, 8'h00, 8'hB6};
	int sk[3] = '{4, 4, 8};
	int wp[4] = '{4{`QPD_SETTING_RESET}};
	int st[4][4] = '{4{'{4{`QPD_SETTING_RESET}}}};
	int fail_count = 0;
	int compares = 0;
	int seed = 63;

	always #50 clk = ~clk;

	qpd_top #(.NV_CYCLES(NV), .DEV_TYPE(DT)) dut_u (.clk(clk), .rst(rst), .sck(sck),
		.cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .addr_strap_pins(ap), .wp_n(wp_n),
		.wiper_pos(wpos), .write_busy_flag(busy));
	qpd_spi_master m_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so_w));

	// compare helpers
	task automatic check(input logic [7:0] seen, input int exp);
		compares++;
		if (seen !== 8'(exp)) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, 8'(exp));
		end
	endtask
	task automatic chk_busy(input int e);
		check({7'h00, busy}, e);
	endtask
	task automatic chk_all();
		for (int c = 0; c < 4; c++) begin
			check(wpos[c], wp[c]);
		end
	endtask
	task automatic nv_wait();
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
		chk_busy(0);
	endtask
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// saturating step model
	function automatic int stepped(int w, logic [7:0] p, int k);
		for (int i = 0; i < k; i++) begin
			w = p[7 - i] ? (w < 255 ? w + 1 : 255) : (w > 0 ? w - 1 : 0);
		end
		return w;
	endfunction

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_all();
		for (int c = 0; c < 4; c++) begin
			v = $random(seed);
			m_u.xfer({id, 6'h28, c[1:0], v}, 24, rb);
			wp[c] = v;
			m_u.xfer({id, 6'h24, c[1:0], 8'h00}, 24, rb);
			check(rb, wp[c]);
		end
		m_u.xfer({id, 8'h88, 8'h00}, 16, rb);
		for (int c = 0; c < 4; c++) st[c][2] = wp[c];
		nv_wait();
		for (int s = 0; s < 4; s++) begin
			v = $random(seed);
			m_u.xfer({id, 4'hC, s[1:0], 2'(s ^ 1), v}, 24, rb);
			st[s ^ 1][s] = v;
			chk_busy(1);
			m_u.xfer({id, `QPD_STATUS_BYTE, 8'h00}, 24, rb);
			check(rb, 1);
			nv_wait();
		end
		m_u.xfer({id, 8'hD6, 8'h00}, 16, rb);
		wp[2] = st[2][1];
		chk_all();
		m_u.xfer({id, 8'hEC, 8'h00}, 16, rb);
		st[0][3] = wp[0];
		nv_wait();
		m_u.xfer({id, 8'h18, 8'h00}, 16, rb);
		for (int c = 0; c < 4; c++) wp[c] = st[c][2];
		chk_all();
		// stepping from loaded starts, saturating at both ends
		for (int t = 0; t < 3; t++) begin
			m_u.xfer({id, 8'hA3, sv[t]}, 24, rb);
			m_u.xfer({id, 8'h23, sp[t]}, 16 + sk[t], rb);
			wp[3] = stepped(sv[t], sp[t], sk[t]);
			chk_all();
		end
		// refused frames change nothing
		m_u.xfer({id ^ 8'h10, 8'hA0, 8'h11}, 24, rb);
		m_u.xfer({id ^ 8'h01, 8'hA0, 8'h22}, 24, rb);
		m_u.xfer({id ^ 8'h10, 8'h90, 8'h00}, 24, rb);
		chk_all();
		m_u.xfer({id, 8'hC0, 8'h33}, 20, rb);
		chk_busy(0);
		@(posedge clk);
		wp_n <= 1'b0;
		m_u.xfer({id, 8'hC0, 8'h5A}, 24, rb);
		chk_busy(0);
		@(posedge clk);
		wp_n <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 4; s++) begin
				m_u.xfer({id, 4'hB, s[1:0], c[1:0], 8'h00}, 24, rb);
				check(rb, st[c][s]);
			end
		end
		give_verdict();
	end

	// watchdog
	initial begin
		#1000000;
		fail_count++;
		$display("mismatch at %0t: timeout", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
